//--- adcr_top.sv
/*
 Control and result registers of a single 12-bit successive-approximation
 converter. Software reaches seven byte registers over a plain strobe port.
 Assumes the analog core runs the conversion itself and returns a one-cycle
 done pulse with its 12-bit result on this same clock.
*/
// Implementation choices: the address map and the address-and-strobe port.
`include "adcr_consts.svh"
module adcr_top (
	input  wire logic               CLK,
	input  wire logic               RESET_N,
	input  wire logic [2:0]         REG_ADDR,
	input  wire adcr_pkg::adcr_byte_t REG_WDATA,
	input  wire logic               REG_WRITE,
	input  wire logic               REG_READ,
	output adcr_pkg::adcr_byte_t    REG_RDATA,
	input  wire logic               CONV_DONE,
	input  wire adcr_pkg::adcr_result_t CONV_RESULT,
	output logic                    CONV_START,
	output logic                    CONV_POWER,
	output logic [11:0]             PIN_CHANNEL_ON,
	output logic [2:0]              INTERNAL_SOURCE,
	output logic                    INTERNAL_ON,
	output logic [2:0]              CLOCK_DIVIDER,
	output adcr_pkg::adcr_byte_t    REFERENCE_CTRL,
	output logic [11:0]             PIN_ANALOG,
	output logic [11:0]             PIN_DIGITAL_OFF,
	output logic [11:0]             PIN_PULLHIGH_OFF
);
	import adcr_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		adcr_state_e  state;
		logic         start_bit;
		logic         busy;
		logic         enable;
		logic         format_right;
		logic [3:0]   channel;
		logic [2:0]   source;
		logic [2:0]   divider;
		adcr_byte_t   reference;
		logic [11:0]  pin_sel;
		adcr_result_t result;
		adcr_byte_t   rdata;
		logic         conv_start;
		logic [11:0]  chan_on;
		logic         internal_on;
		logic [11:0]  dig_off;
	} adcr_regs_s;

	adcr_regs_s r_q;
	adcr_regs_s r_d;

	adcr_byte_t res_high;
	adcr_byte_t res_low;
	adcr_byte_t control_0;
	logic       is_internal;

	adcr_pack u_pack (
		.format_right (r_q.format_right),
		.value        (r_q.result),
		.high_byte    (res_high),
		.low_byte     (res_low)
	);

	// ------------------------------------------------------------------------
	// Control byte read-back and source decode
	// ------------------------------------------------------------------------
	always_comb begin
		control_0 = {r_q.start_bit, r_q.busy, r_q.enable, r_q.format_right, r_q.channel};
		is_internal = (r_q.source != ADCR_SRC_EXT0) && (r_q.source != ADCR_SRC_EXT1);
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.conv_start = 1'b0;

		if (REG_WRITE) begin
			unique case (REG_ADDR)
				`ADCR_OFF_CONTROL_0: begin
					r_d.start_bit    = REG_WDATA[`ADCR_C0_START_BIT];
					r_d.enable       = REG_WDATA[`ADCR_C0_ENABLE_BIT];
					r_d.format_right = REG_WDATA[`ADCR_C0_FORMAT_BIT];
					r_d.channel      = REG_WDATA[3:0];
				end
				`ADCR_OFF_CONTROL_1: begin
					r_d.source  = REG_WDATA[7:5];
					r_d.divider = REG_WDATA[2:0];
				end
				`ADCR_OFF_REF_CONTROL: r_d.reference = REG_WDATA;
				`ADCR_OFF_PIN_SEL_LOW: r_d.pin_sel[7:0] = REG_WDATA;
				`ADCR_OFF_PIN_SEL_HIGH: r_d.pin_sel[11:8] = REG_WDATA[3:0];
				// Result offsets and unmapped ones ignore writes.
				default: r_d.result = r_q.result;
			endcase
		end

		// Start needs a full high-then-low sequence; a conversion in flight
		// is not restarted, so the core only ever sees one start per conversion.
		unique case (r_q.state)
			ADCR_IDLE: begin
				if (r_d.start_bit && !r_q.start_bit)
					r_d.state = ADCR_ARMED;
			end
			ADCR_ARMED: begin
				if (!r_d.start_bit && r_q.enable) begin
					r_d.state      = ADCR_CONVERTING;
					r_d.busy       = 1'b1;
					r_d.conv_start = 1'b1;
				end
			end
			ADCR_CONVERTING: begin
				if (!r_q.enable) begin
					// Switched off mid-way: abandon, keep the old result.
					r_d.state = ADCR_IDLE;
					r_d.busy  = 1'b0;
				end else if (CONV_DONE) begin
					r_d.state  = ADCR_IDLE;
					r_d.busy   = 1'b0;
					r_d.result = CONV_RESULT;
				end
			end
			default: r_d.state = ADCR_IDLE;
		endcase

		// External channel routing; codes above the last pin float.
		r_d.chan_on = '0;
		if (!is_internal && r_q.channel <= `ADCR_CHAN_LAST)
			r_d.chan_on[r_q.channel] = 1'b1;
		r_d.internal_on = is_internal;
		r_d.dig_off = r_q.pin_sel;

		r_d.rdata = `ADCR_RESET_BYTE;
		if (REG_READ) begin
			unique case (REG_ADDR)
				`ADCR_OFF_RESULT_LOW:   r_d.rdata = res_low;
				`ADCR_OFF_RESULT_HIGH:  r_d.rdata = res_high;
				`ADCR_OFF_CONTROL_0:    r_d.rdata = control_0;
				`ADCR_OFF_CONTROL_1:    r_d.rdata = {r_q.source, 2'b00, r_q.divider};
				`ADCR_OFF_REF_CONTROL:  r_d.rdata = r_q.reference;
				`ADCR_OFF_PIN_SEL_LOW:  r_d.rdata = r_q.pin_sel[7:0];
				`ADCR_OFF_PIN_SEL_HIGH: r_d.rdata = {4'h0, r_q.pin_sel[11:8]};
				default:                r_d.rdata = `ADCR_RESET_BYTE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r_q <= '0;
		end else begin
			r_q <= r_d;
		end
	end

	always_comb begin
		REG_RDATA        = r_q.rdata;
		CONV_START       = r_q.conv_start;
		CONV_POWER       = r_q.enable;
		PIN_CHANNEL_ON   = r_q.chan_on;
		INTERNAL_SOURCE  = r_q.source;
		INTERNAL_ON      = r_q.internal_on;
		CLOCK_DIVIDER    = r_q.divider;
		REFERENCE_CTRL   = r_q.reference;
		PIN_ANALOG       = r_q.dig_off;
		PIN_DIGITAL_OFF  = r_q.dig_off;
		PIN_PULLHIGH_OFF = r_q.dig_off;
	end
endmodule

//--- adcr_consts.svh
/*
 Register offsets, field positions, reset values and pin counts of the
 converter control block. Assumes inclusion by bare name from package and modules.
*/
`ifndef ADCR_CONSTS_SVH
`define ADCR_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define ADCR_OFF_RESULT_LOW   3'h0
`define ADCR_OFF_RESULT_HIGH  3'h1
`define ADCR_OFF_CONTROL_0    3'h2
`define ADCR_OFF_CONTROL_1    3'h3
`define ADCR_OFF_REF_CONTROL  3'h4
`define ADCR_OFF_PIN_SEL_LOW  3'h5
`define ADCR_OFF_PIN_SEL_HIGH 3'h6

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ADCR_C0_START_BIT     7
`define ADCR_C0_BUSY_BIT      6
`define ADCR_C0_ENABLE_BIT    5
`define ADCR_C0_FORMAT_BIT    4
`define ADCR_C1_SRC_LSB       5
`define ADCR_C1_WRITE_MASK    8'hE7
`define ADCR_PINH_WRITE_MASK  8'h0F

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define ADCR_RESET_BYTE       8'h00
`define ADCR_RESET_RESULT     12'h000
`define ADCR_NUM_PINS         12
`define ADCR_CHAN_LAST        4'hB

`endif

//--- adcr_pkg.sv
/*
 Types shared by the converter control block.
 Assumes adcr_consts.svh is on the include path.
*/
package adcr_pkg;
	`include "adcr_consts.svh"

	typedef enum logic [2:0] {
		ADCR_SRC_EXT0,
		ADCR_SRC_VDD,
		ADCR_SRC_VDD_HALF,
		ADCR_SRC_VDD_QUARTER,
		ADCR_SRC_EXT1,
		ADCR_SRC_VREF,
		ADCR_SRC_VREF_HALF,
		ADCR_SRC_VREF_QUARTER
	} adcr_src_e;

	typedef enum logic [1:0] {
		ADCR_IDLE,
		ADCR_ARMED,
		ADCR_CONVERTING
	} adcr_state_e;

	typedef logic [7:0]  adcr_byte_t;
	typedef logic [11:0] adcr_result_t;
endpackage

//--- adcr_pack.sv
/*
 Packs a 12-bit result into a high and low byte in either alignment.
 Assumes a purely combinational use inside the control block.
*/
module adcr_pack (
	input  wire logic              format_right,
	input  wire adcr_pkg::adcr_result_t value,
	output adcr_pkg::adcr_byte_t        high_byte,
	output adcr_pkg::adcr_byte_t        low_byte
);
	import adcr_pkg::*;

	// Unused positions are filled with zero in both layouts.
	always_comb begin
		if (format_right) begin
			high_byte = {4'h0, value[11:8]};
			low_byte  = value[7:0];
		end else begin
			high_byte = value[11:4];
			low_byte  = {value[3:0], 4'h0};
		end
	end
endmodule

//--- adcr_chk.sv
/*
 Concurrent checks on the ports of the converter control block.
 Assumes a bind from the bench and one clock domain.
*/
module adcr_chk
	import adcr_pkg::*;
(
	input wire logic        CLK,
	input wire logic        RESET_N,
	input wire logic [2:0]  REG_ADDR,
	input wire adcr_byte_t  REG_WDATA,
	input wire logic        REG_WRITE,
	input wire logic        REG_READ,
	input wire adcr_byte_t  REG_RDATA,
	input wire logic        CONV_START,
	input wire logic [11:0] PIN_CHANNEL_ON,
	input wire logic [2:0]  INTERNAL_SOURCE,
	input wire logic        INTERNAL_ON,
	input wire logic [11:0] PIN_ANALOG,
	input wire logic [11:0] PIN_DIGITAL_OFF,
	input wire logic [11:0] PIN_PULLHIGH_OFF
);
	logic [2:0] wsrc;
	assign wsrc = REG_WDATA[7:5];
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	chk_dig_off: assert property (PIN_DIGITAL_OFF == PIN_ANALOG)
		else $error("digital off differs");
	chk_pull_off: assert property (PIN_PULLHIGH_OFF == PIN_ANALOG)
		else $error("pull-high off differs");
	chk_ext_cut: assert property (INTERNAL_ON |-> PIN_CHANNEL_ON == 12'h000)
		else $error("pin routed with internal source");
	chk_one_src: assert property ($onehot0(PIN_CHANNEL_ON))
		else $error("several pins routed");
	chk_src_decode: assert property (INTERNAL_ON == ($past(INTERNAL_SOURCE[1:0]) != 2'h0))
		else $error("internal flag wrong");
	chk_start_pulse: assert property (CONV_START |=> !CONV_START)
		else $error("start longer than one cycle");
	chk_pin_low: assert property (REG_WRITE && REG_ADDR == 3'h5 |=> ##1 PIN_ANALOG[7:0] == $past(REG_WDATA, 2))
		else $error("pin select not applied");
	chk_src_write: assert property (REG_WRITE && REG_ADDR == 3'h3 |=> ##1 INTERNAL_SOURCE == $past(wsrc, 2))
		else $error("source field not applied");
	chk_rd_idle: assert property (!REG_READ |=> REG_RDATA == 8'h00)
		else $error("read data outside read");
endmodule

//--- adcr_core_model.sv
/*
 Behavioural analog core: answers a start with a done pulse dly+1 cycles after the edge that samples it.
 Assumes the same clock as the control block.
*/
module adcr_core_model (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        start,
	input wire logic [31:0] dly,
	input wire logic [11:0] value,
	output logic            done,
	output logic [11:0]     result
);
	int   cnt;
	logic busy;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 0;
		end else begin
			done <= 1'b0;
			cnt <= cnt + 1;
			if (start) begin
				busy <= 1'b1;
				cnt <= 0;
			end else if (busy && cnt >= dly) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
		end
	end
	// Outside the done pulse the bus churns, so a late sample cannot pass.
	assign result = done ? value : ~value ^ cnt[11:0];
endmodule

//--- adcr_tb_top.sv
/*
 Self-checking bench of the converter control block.
 Assumes the model and checker files are compiled first.
*/
module adcr_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import adcr_pkg::*;
	logic        CLK = 1'b0, RESET_N = 1'b0, REG_WRITE = 1'b0, REG_READ = 1'b0;
	logic [2:0]  REG_ADDR = 3'h0, INTERNAL_SOURCE, CLOCK_DIVIDER;
	adcr_byte_t  REG_WDATA = 8'h00, REG_RDATA, REFERENCE_CTRL;
	logic        CONV_DONE, CONV_START, CONV_POWER, INTERNAL_ON;
	logic [11:0] CONV_RESULT, PIN_CHANNEL_ON, PIN_ANALOG, PIN_DIGITAL_OFF, PIN_PULLHIGH_OFF;
	logic [11:0] value = 12'h000;
	int          dly = 2, mismatches = 0, n_compared = 0;
	// Row: format, source code, channel code, core value.
	logic [19:0] rows [8] = '{20'h03ABC, 20'hCB5A5, 20'h12FFF, 20'hA5123,
	                          20'h37800, 20'hD0001, 20'h697E1, 20'h8C9C3};
	always #4 CLK = ~CLK;
	adcr_top i_adcr_top (.CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WRITE, .REG_READ,
		.REG_RDATA, .CONV_DONE, .CONV_RESULT, .CONV_START, .CONV_POWER, .PIN_CHANNEL_ON,
		.INTERNAL_SOURCE, .INTERNAL_ON, .CLOCK_DIVIDER, .REFERENCE_CTRL, .PIN_ANALOG,
		.PIN_DIGITAL_OFF, .PIN_PULLHIGH_OFF);
	adcr_core_model i_adcr_core_model (.clk(CLK), .rst_n(RESET_N), .start(CONV_START),
		.dly, .value, .done(CONV_DONE), .result(CONV_RESULT));
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [2:0] a, input adcr_byte_t d);
		@(posedge CLK);
		REG_WRITE <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK);
		REG_WRITE <= 1'b0;
	endtask
	task automatic rd(input logic [2:0] a, output adcr_byte_t d);
		@(posedge CLK);
		REG_READ <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK);
		REG_READ <= 1'b0;
		#1 d = REG_RDATA;
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_idle();
		adcr_byte_t d;
		for (int k = 0; k < 100; k++) begin
			rd(3'h2, d);
			if (d[6] === 1'b0)
				return;
		end
		mismatches++;
		finish_test();
	endtask
	initial begin
		adcr_byte_t  h, l;
		logic [19:0] r;
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		for (int a = 2; a < 8; a++) begin
			rd(a[2:0], h);
			cmp({8'h00, h}, 16'h0000);
		end
		for (int i = 0; i < 8; i++) begin
			r = rows[i];
			dly = 2 + 5 * i;
			value = r[11:0];
			wr(3'h3, {r[18:16], 2'b00, i[2:0]});
			wr(3'h2, {3'b101, r[19], r[15:12]});
			wr(3'h2, {3'b001, r[19], r[15:12]});
			wait_idle();
			rd(3'h1, h);
			rd(3'h0, l);
			cmp({h, l}, r[19] ? {4'h0, r[11:0]} : {r[11:0], 4'h0});
			cmp({4'h0, PIN_CHANNEL_ON}, (r[17:16] == 2'h0 && r[15:12] < 4'hC) ?
				16'h1 << r[15:12] : 16'h0);
			cmp({9'h0, INTERNAL_ON, INTERNAL_SOURCE, CLOCK_DIVIDER},
				{9'h0, r[17:16] != 2'h0, r[18:16], i[2:0]});
		end
		wr(3'h0, 8'hFF);
		wr(3'h1, 8'hFF);
		rd(3'h1, h);
		rd(3'h0, l);
		cmp({h, l}, 16'h09C3);
		value = 12'h456;
		wr(3'h2, 8'h90);
		wr(3'h2, 8'h10);
		rd(3'h1, h);
		rd(3'h0, l);
		cmp({h, l}, 16'h09C3);
		cmp({15'h0000, CONV_POWER}, 16'h0000);
		wr(3'h2, 8'hA0);
		rd(3'h2, h);
		cmp({8'h00, h}, 16'h00A0);
		wr(3'h2, 8'h20);
		wait_idle();
		rd(3'h1, h);
		rd(3'h0, l);
		cmp({h, l}, 16'h4560);
		wr(3'h5, 8'hFF);
		wr(3'h6, 8'hFF);
		rd(3'h6, h);
		cmp({h, PIN_ANALOG[11:4]}, 16'h0FFF);
		cmp({4'h0, PIN_PULLHIGH_OFF}, 16'h0FFF);
		cmp({4'h0, PIN_DIGITAL_OFF}, 16'h0FFF);
		wr(3'h4, 8'hA5);
		rd(3'h4, h);
		cmp({h, REFERENCE_CTRL}, 16'hA5A5);
		// Mid-run reset: registers clear and derived outputs follow the cleared codes, so pin 0 is routed.
		@(posedge CLK);
		RESET_N <= 1'b0;
		repeat (3) @(posedge CLK);
		RESET_N <= 1'b1;
		rd(3'h1, h);
		rd(3'h0, l);
		cmp({h, l}, 16'h0000);
		rd(3'h6, h);
		cmp({h, 4'h0, PIN_ANALOG[11:8]}, 16'h0000);
		cmp({4'h0, PIN_CHANNEL_ON}, 16'h0001);
		finish_test();
	end
endmodule
bind adcr_top adcr_chk i_adcr_chk (.CLK, .RESET_N, .REG_ADDR, .REG_WDATA, .REG_WRITE,
	.REG_READ, .REG_RDATA, .CONV_START, .PIN_CHANNEL_ON, .INTERNAL_SOURCE, .INTERNAL_ON,
	.PIN_ANALOG, .PIN_DIGITAL_OFF, .PIN_PULLHIGH_OFF);
